// *** core/scc_params.svh ***
// offsets, field positions, reset values and timing counts of the configuration register
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_SYSCFG_OFFSET      32'h0000_0000
`define SCC_ADDR_WIDTH         32
`define SCC_DATA_WIDTH         32

`define SCC_TRIM_MSB           19
`define SCC_TRIM_LSB           12
`define SCC_REG_ON_BIT         11
`define SCC_TX_EN_BIT          10
`define SCC_LISTEN_BIT         9
`define SCC_SOFT_RESET_BIT     8
`define SCC_RFU7_BIT           7
`define SCC_CRYPTO_BIT         6
`define SCC_PRBS_SEL_BIT       5
`define SCC_RFU4_BIT           4
`define SCC_START_BIT          3
`define SCC_CMD_MSB            2
`define SCC_CMD_LSB            0

`define SCC_CMD_RESET          3'h1
`define SCC_CMD_STOP           3'h0
`define SCC_CMD_TRANSCEIVE     3'h3
`define SCC_CMD_KEEP           3'h4
`define SCC_CMD_LOOPBACK       3'h5
`define SCC_CMD_PRBS           3'h6

`define SCC_CLK_MHZ            40
`define SCC_FIELD_ON_DELAY_NS  1000
`define SCC_FIELD_ON_CYC       ((`SCC_FIELD_ON_DELAY_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_DELAY_CNT_W        8

`endif

// *** core/scc_pkg.sv ***
// types of the configuration register block
package scc_pkg;

	typedef struct packed {
		logic [7:0] trim;
		logic       reg_on;
		logic       tx_en;
		logic       listen;
		logic       rfu7;
		logic       crypto;
		logic       prbs_sel;
		logic       rfu4;
		logic       start;
		logic [2:0] cmd;
	} scc_cfg_type;

	typedef struct packed {
		logic reader_mode;
		logic active_mode;
		logic first_field_on_setting;
		logic automatic_field_on_setting;
		logic collision_avoid_field_on;
	} scc_field_ctl_type;

	typedef enum logic [1:0] {
		SCC_HTRANS_IDLE   = 2'h0,
		SCC_HTRANS_BUSY   = 2'h1,
		SCC_HTRANS_NONSEQ = 2'h2,
		SCC_HTRANS_SEQ    = 2'h3
	} scc_htrans_type;

endpackage : scc_pkg

// *** core/scc_top.sv ***
// system configuration and command register with transceive control, AHB-Lite slave
//
// Register access over AHB-Lite was left to the implementer.
`include "scc_params.svh"

// Summary of operation
// - signed trim added to offset and gain
// - bit 11 switches regulator output on
// - bit 10 plus reader/active mode drives transmitter
// - driver turns on after field-on delay, or at once with first field-on setting
// - field active fault clears bit 10
// - bit 9 gives listen entry state
// - writing 1 to bit 8 resets device
// - bit 6 enables stream crypto unit
// - bit 5 picks 15 or 9 bit sequence
// - writing bit 3 triggers a transmission
// - bits 2:0 command field, reset 001
// - code 000 stops, goes idle
// - code 011 transmits or receives by role
// - transceive persists until code 000, 101 or 110 or a soft reset
// - code 100 keeps stored command
// - code 101 transmits and receives together
// - code 110 sends sequence endlessly
module scc_top #(
	parameter int GAIN_W = 10
) (
	input  wire logic                              hclk,
	input  wire logic                              hresetn,
	input  wire logic                              hsel,
	input  wire logic [`SCC_ADDR_WIDTH-1:0]        haddr,
	input  wire logic [1:0]                        htrans,
	input  wire logic                              hwrite,
	input  wire logic [2:0]                        hsize,
	input  wire logic                              hready,
	input  wire logic [`SCC_DATA_WIDTH-1:0]        hwdata,
	output logic      [`SCC_DATA_WIDTH-1:0]        hrdata,
	output logic                                   hreadyout,
	output logic                                   hresp,
	input  wire logic                              initiator_mode,
	input  wire scc_pkg::scc_field_ctl_type        field_ctl,
	input  wire logic                              ext_field_present,
	input  wire logic                              field_active_fault,
	input  wire logic signed [7:0]                 power_ctrl_stored_offset,
	input  wire logic signed [GAIN_W-1:0]          actual_gain,
	output logic signed [GAIN_W+1:0]               resulting_gain,
	output logic                                   regulator_output_on,
	output logic                                   transmitter_driver_on,
	output logic                                   listen_entry_state,
	output logic                                   soft_reset_pulse,
	output logic                                   crypto_enable,
	output logic                                   pseudo_random_length_sel,
	output logic                                   tx_start_pulse,
	output logic                                   tx_active,
	output logic                                   rx_enable,
	output logic                                   prbs_run
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_XCV_TX,
		ST_XCV_RX,
		ST_LOOP,
		ST_PRBS
	} scc_state_type;

	localparam scc_pkg::scc_cfg_type CFG_RESET = '{cmd: `SCC_CMD_RESET, default: '0};
	localparam logic [`SCC_DELAY_CNT_W-1:0] FIELD_ON_CYC = `SCC_DELAY_CNT_W'(`SCC_FIELD_ON_CYC);

	function automatic logic addr_hit(input logic [`SCC_ADDR_WIDTH-1:0] a);
		addr_hit = (a == `SCC_SYSCFG_OFFSET);
	endfunction : addr_hit

	function automatic logic [`SCC_DATA_WIDTH-1:0] pack_cfg(input scc_pkg::scc_cfg_type c);
		pack_cfg = {12'h000, c.trim, c.reg_on, c.tx_en, c.listen, 1'b0, c.rfu7, c.crypto,
			c.prbs_sel, c.rfu4, c.start, c.cmd};
	endfunction : pack_cfg

	scc_pkg::scc_cfg_type cfg_ff;
	scc_pkg::scc_cfg_type nxt_cfg;
	scc_state_type        state_ff;
	scc_state_type        nxt_state;
	logic                 wr_pend_ff;
	logic                 wr_hit_ff;
	logic                 addr_phase;
	logic                 wr_now;
	logic                 soft_rst_now;
	logic                 start_now;
	logic                 ext_meta_ff;
	logic                 ext_sync_ff;
	logic [`SCC_DELAY_CNT_W-1:0] delay_cnt_ff;
	logic                 field_want;
	logic                 field_blocked;

	assign addr_phase   = hsel && hready && htrans[1];
	assign wr_now       = wr_pend_ff && wr_hit_ff;
	assign soft_rst_now = wr_now && hwdata[`SCC_SOFT_RESET_BIT];
	assign start_now    = wr_now && !soft_rst_now && hwdata[`SCC_START_BIT];

	always_comb
	begin
		nxt_cfg = cfg_ff;
		if (soft_rst_now)
		begin
			nxt_cfg = CFG_RESET;
		end
		else if (wr_now)
		begin
			nxt_cfg.trim     = hwdata[`SCC_TRIM_MSB:`SCC_TRIM_LSB];
			nxt_cfg.reg_on   = hwdata[`SCC_REG_ON_BIT];
			nxt_cfg.tx_en    = hwdata[`SCC_TX_EN_BIT];
			nxt_cfg.listen   = hwdata[`SCC_LISTEN_BIT];
			nxt_cfg.rfu7     = hwdata[`SCC_RFU7_BIT];
			nxt_cfg.crypto   = hwdata[`SCC_CRYPTO_BIT];
			nxt_cfg.prbs_sel = hwdata[`SCC_PRBS_SEL_BIT];
			nxt_cfg.rfu4     = hwdata[`SCC_RFU4_BIT];
			nxt_cfg.start    = hwdata[`SCC_START_BIT];
			if (hwdata[`SCC_CMD_MSB:`SCC_CMD_LSB] != `SCC_CMD_KEEP)
			begin
				nxt_cfg.cmd = hwdata[`SCC_CMD_MSB:`SCC_CMD_LSB];
			end
		end
		// applied last: a fault beats a same-cycle write
		// hardware clears enable
		if (field_active_fault)
		begin
			nxt_cfg.tx_en = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cfg_ff <= CFG_RESET;
		else
			cfg_ff <= nxt_cfg;
	end

	// bus slave: zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			wr_hit_ff  <= 1'b0;
			hrdata     <= '0;
			hreadyout  <= 1'b0;
			hresp      <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready)
			begin
				wr_pend_ff <= addr_phase && hwrite;
				wr_hit_ff  <= addr_phase && addr_hit(haddr);
			end
			// next value, so a read right after a write sees it
			if (addr_phase && !hwrite)
				hrdata <= addr_hit(haddr) ? pack_cfg(nxt_cfg) : '0;
		end
	end

	// one-cycle strobes to the rest of the device
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			soft_reset_pulse <= 1'b0;
			tx_start_pulse   <= 1'b0;
		end
		else
		begin
			soft_reset_pulse <= soft_rst_now;
			tx_start_pulse   <= start_now;
		end
	end

	always_comb
	begin
		nxt_state = state_ff;
		unique case (cfg_ff.cmd)
			`SCC_CMD_STOP:
				nxt_state = ST_IDLE;
			`SCC_CMD_TRANSCEIVE:
			begin
				if (state_ff != ST_XCV_TX && state_ff != ST_XCV_RX)
					nxt_state = initiator_mode ? ST_XCV_TX : ST_XCV_RX;
				else if (state_ff == ST_XCV_RX && start_now)
					nxt_state = ST_XCV_TX;
			end
			`SCC_CMD_LOOPBACK:
				nxt_state = ST_LOOP;
			`SCC_CMD_PRBS:
				nxt_state = ST_PRBS;
			default:
				nxt_state = state_ff;
		endcase
		if (soft_rst_now)
			nxt_state = ST_IDLE;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff  <= ST_IDLE;
			tx_active <= 1'b0;
			rx_enable <= 1'b0;
			prbs_run  <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			// decoded from next state to save a cycle
			tx_active <= (nxt_state == ST_XCV_TX) || (nxt_state == ST_LOOP) || (nxt_state == ST_PRBS);
			rx_enable <= (nxt_state == ST_XCV_RX) || (nxt_state == ST_LOOP);
			prbs_run  <= (nxt_state == ST_PRBS);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_meta_ff <= 1'b0;
			ext_sync_ff <= 1'b0;
		end
		else
		begin
			// field-detect pin crosses in through two flops
			ext_meta_ff <= ext_field_present;
			ext_sync_ff <= ext_meta_ff;
		end
	end

	assign field_want    = cfg_ff.tx_en && (field_ctl.reader_mode || field_ctl.active_mode);
	// an outside field only holds off turn-on
	assign field_blocked = (field_ctl.collision_avoid_field_on || field_ctl.automatic_field_on_setting)
		&& ext_sync_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			delay_cnt_ff          <= '0;
			transmitter_driver_on <= 1'b0;
		end
		else if (!field_want || (field_blocked && !transmitter_driver_on))
		begin
			delay_cnt_ff          <= '0;
			transmitter_driver_on <= 1'b0;
		end
		else if (field_ctl.first_field_on_setting || delay_cnt_ff >= FIELD_ON_CYC - 1'b1)
		begin
			transmitter_driver_on <= 1'b1;
		end
		else
		begin
			// counts only while wanted and not held off
			delay_cnt_ff <= delay_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			resulting_gain           <= '0;
			regulator_output_on      <= 1'b0;
			listen_entry_state       <= 1'b0;
			crypto_enable            <= 1'b0;
			pseudo_random_length_sel <= 1'b0;
		end
		else
		begin
			resulting_gain           <= (GAIN_W+2)'(actual_gain) + (GAIN_W+2)'(power_ctrl_stored_offset)
				+ (GAIN_W+2)'($signed(cfg_ff.trim));
			regulator_output_on      <= cfg_ff.reg_on;
			listen_entry_state       <= cfg_ff.listen;
			crypto_enable            <= cfg_ff.crypto;
			pseudo_random_length_sel <= cfg_ff.prbs_sel;
		end
	end

endmodule : scc_top

// *** test/scc_top_asserts.sv ***
// port-level assertions of the configuration register block
module scc_top_asserts (
	input wire logic                       hclk,
	input wire logic                       hresetn,
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic                       hready,
	input wire logic [31:0]                hwdata,
	input wire scc_pkg::scc_field_ctl_type field_ctl,
	input wire logic                       field_active_fault,
	input wire logic                       regulator_output_on,
	input wire logic                       transmitter_driver_on,
	input wire logic                       crypto_enable,
	input wire logic                       soft_reset_pulse,
	input wire logic                       tx_start_pulse,
	input wire logic                       tx_active,
	input wire logic                       prbs_run
);
	logic wr_ff;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// marks the data phase of a write to the register
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wr_ff <= 1'b0;
		else
			wr_ff <= hsel && hready && htrans[1] && hwrite && (haddr == 32'h0000_0000);

	regulator_follow_a: assert property (
		wr_ff && !hwdata[8] |-> ##2 regulator_output_on == $past(hwdata[11], 2))
		else $error("regulator output wrong");
	crypto_follow_a: assert property (
		wr_ff && !hwdata[8] |-> ##2 crypto_enable == $past(hwdata[6], 2))
		else $error("crypto enable wrong");
	soft_pulse_a: assert property (
		wr_ff && hwdata[8] |=> soft_reset_pulse ##1 !soft_reset_pulse)
		else $error("soft reset pulse wrong");
	start_pulse_a: assert property (
		tx_start_pulse |-> $past(wr_ff && hwdata[3] && !hwdata[8]))
		else $error("start pulse without write");
	fault_clear_a: assert property (
		field_active_fault |-> ##2 !transmitter_driver_on)
		else $error("driver on after fault");
	mode_gate_a: assert property (
		!(field_ctl.reader_mode || field_ctl.active_mode) |=> !transmitter_driver_on)
		else $error("driver on outside mode");
	hold_state_a: assert property (
		$fell(tx_active) |-> $past(wr_ff, 2) || $past(wr_ff && hwdata[8]))
		else $error("transmit ended by itself");
	prbs_tx_a: assert property (
		prbs_run |-> tx_active)
		else $error("sequence without transmit");
endmodule : scc_top_asserts

// *** test/scc_top_test.sv ***
// self-checking bench of the configuration register over its host bus
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: %h", $time, g); end end

module scc_top_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic                       hclk = 1'b0;
	logic                       hresetn = 1'b0;
	logic                       hsel = 1'b0;
	logic                       hwrite = 1'b0;
	logic                       initiator_mode = 1'b0;
	logic                       field_active_fault = 1'b0;
	logic [1:0]                 htrans = 2'h0;
	logic [31:0]                haddr = 32'h0;
	logic [31:0]                hwdata = 32'h0;
	logic [31:0]                hrdata;
	logic [31:0]                q;
	logic                       hreadyout;
	logic                       hresp;
	logic                       ext_field_present = 1'b0;
	scc_pkg::scc_field_ctl_type field_ctl = 5'h14;
	logic signed [11:0]         resulting_gain;
	logic                       regulator_output_on, transmitter_driver_on, listen_entry_state;
	logic                       soft_reset_pulse, crypto_enable, pseudo_random_length_sel;
	logic                       tx_start_pulse, tx_active, rx_enable, prbs_run;
	int                         err_count = 0;
	int                         tests_run = 0;

	scc_top i_scc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .initiator_mode, .field_ctl, .ext_field_present,
		.field_active_fault, .power_ctrl_stored_offset(8'sh05), .actual_gain(10'sh064), .resulting_gain,
		.regulator_output_on, .transmitter_driver_on, .listen_entry_state, .soft_reset_pulse, .crypto_enable,
		.pseudo_random_length_sel, .tx_start_pulse, .tx_active, .rx_enable, .prbs_run);

	always #12.5 hclk = ~hclk;

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic results;
		$display("tests run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	initial
	begin
		cyc(5000);
		err_count++;
		results();
	end

	initial
	begin
		cyc(5);
		hresetn <= 1'b1;
		cyc(1);
		bus(0, 32'h0, 32'h0);
		`CHK(q, 32'h0000_0001)
		bus(1, 32'h0, 32'h000F_FE66);
		bus(0, 32'h0, 32'h0);
		`CHK(q, 32'h000F_FE66)
		cyc(3);
		`CHK({regulator_output_on, listen_entry_state, crypto_enable, pseudo_random_length_sel}, 4'hF)
		`CHK({prbs_run, tx_active, rx_enable}, 3'h6)
		`CHK(resulting_gain, 12'sh068)
		`CHK(transmitter_driver_on, 1'b1)
		bus(1, 32'h0, 32'h4);
		bus(0, 32'h0, 32'h0);
		`CHK(q, 32'h0000_0006)
		cyc(3);
		`CHK({prbs_run, pseudo_random_length_sel}, 2'h2)
		$display("test fields done");
		bus(1, 32'h0, 32'h3);
		cyc(3);
		`CHK({tx_active, rx_enable}, 2'h1)
		bus(1, 32'h0, 32'hB);
		cyc(30);
		`CHK({tx_active, rx_enable}, 2'h2)
		bus(1, 32'h0, 32'h0);
		cyc(3);
		`CHK({tx_active, rx_enable, prbs_run}, 3'h0)
		initiator_mode <= 1'b1;
		bus(1, 32'h0, 32'h3);
		cyc(3);
		`CHK({tx_active, rx_enable}, 2'h2)
		bus(1, 32'h0, 32'h5);
		cyc(3);
		`CHK({tx_active, rx_enable}, 2'h3)
		$display("test commands done");
		field_ctl <= 5'h11;
		ext_field_present <= 1'b1;
		bus(1, 32'h0, 32'h404);
		cyc(50);
		`CHK(transmitter_driver_on, 1'b0)
		ext_field_present <= 1'b0;
		cyc(10);
		`CHK(transmitter_driver_on, 1'b0)
		cyc(50);
		`CHK(transmitter_driver_on, 1'b1)
		field_active_fault <= 1'b1;
		cyc(1);
		field_active_fault <= 1'b0;
		bus(0, 32'h0, 32'h0);
		`CHK(q[10], 1'b0)
		field_ctl <= 5'h00;
		bus(1, 32'h0, 32'h0000_0F66);
		bus(0, 32'h0, 32'h0);
		`CHK(q, 32'h0000_0001)
		bus(1, 32'h4, 32'h0000_00FF);
		bus(0, 32'h4, 32'h0);
		`CHK(q, 32'h0)
		`CHK(hresp, 1'b0)
		bus(0, 32'h0, 32'h0);
		`CHK(q, 32'h0000_0001)
		$display("test field and reset done");
		results();
	end
endmodule : scc_top_test

bind scc_top scc_top_asserts i_scc_top_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hwdata, .field_ctl, .field_active_fault, .regulator_output_on, .transmitter_driver_on, .crypto_enable,
	.soft_reset_pulse, .tx_start_pulse, .tx_active, .prbs_run);
